//--- rtl/dsbrc_defs.vh
// Constants for the upper-bank refresh and configuration block.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef DSBRC_DEFS_VH
`define DSBRC_DEFS_VH
// ========================================
// Register offsets (byte addresses)
`define DSBRC_ADDR_BANK_LOWER 32'h01c8_001c
`define DSBRC_ADDR_BANK_UPPER 32'h01c8_0020
`define DSBRC_ADDR_REFRESH 32'h01c8_0024
`define DSBRC_ADDR_BANK_SIZE_MAP 32'h01c8_0028
`define DSBRC_ADDR_MODE_LOWER 32'h01c8_002c
`define DSBRC_ADDR_MODE_UPPER 32'h01c8_0030
`define DSBRC_ADDR_STATUS 32'h01c8_0034
// ========================================
// Reset values
`define DSBRC_RST_REFRESH 24'hac_0000
`define DSBRC_RST_BANK 17'h1_8008
`define DSBRC_RST_BANK_SIZE_MAP 5'h00
`define DSBRC_RST_MODE 12'h000
`define DSBRC_RST_TRCD 3'h4
`define DSBRC_RST_TRP 3'h4
`define DSBRC_RST_TRC 3'h7
`define DSBRC_RST_SIZE_MB 6'h20
// ========================================
// Field positions
`define DSBRC_MT_HI 16
`define DSBRC_MT_LO 15
`define DSBRC_REF_EN 23
`define DSBRC_REF_MODE 22
`define DSBRC_TRP_HI 21
`define DSBRC_TRP_LO 20
`define DSBRC_TRC_HI 19
`define DSBRC_TRC_LO 18
`define DSBRC_TCHR_HI 17
`define DSBRC_TCHR_LO 16
`define DSBRC_CNT_HI 10
`define DSBRC_CLKGATE 4
`define DSBRC_MAP_HI 2
// ========================================
// Memory types
`define DSBRC_MT_STATIC 2'h0
`define DSBRC_MT_FPDRAM 2'h1
`define DSBRC_MT_EDO 2'h2
`define DSBRC_MT_SDRAM 2'h3
// ========================================
// Timing bases in clocks; column width base in bits
`define DSBRC_TRCD_BASE 3'h2
`define DSBRC_TRP_SD_BASE 3'h2
`define DSBRC_TRP_DR_BASE 3'h2
`define DSBRC_TRC_BASE 3'h4
`define DSBRC_TCHR_BASE 3'h1
`define DSBRC_COL_BASE 4'h8
`define DSBRC_CNT_TOP 12'h800
`endif

//--- rtl/dsbrc_top.v
// Refresh engine, bank configuration and mode-set issue for the two upper banks.
// Assumes a same-clock register port and an external arbiter acknowledging refresh.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "dsbrc_defs.vh"
// ========================================
// Summary of operation
// - Memory type field 00 static, 01 fast page, 10 EDO, 11 SDRAM per bank.
// - SDRAM row-to-column delay codes 00,01,10 give 2,3,4 clocks; default 4.
// - SDRAM column width codes 00,01,10 give 8,9,10 bits; default 8.
// - Refresh enable bit 23 permits refresh; set after reset.
// - Refresh mode bit 22: 0 auto refresh, 1 self refresh; clear after reset.
// - During self refresh, memory controls are held at self-refresh levels.
// - Precharge field: DRAM 1.5-4.5 clocks, SDRAM 2-4 clocks; default code 10.
// - SDRAM row-cycle field gives 4 to 7 clocks; default code 11.
// - DRAM CAS hold in refresh gives 1 to 4 clocks; default 00.
// - Refresh interval is two to the eleventh minus count plus one clocks.
// - Refresh control bits 15 to 11 read as zero.
// - Clock gating bit 4 set: memory clock toggles only during SDRAM cycles.
// - Map field sets upper bank sizes 32M,2M,4M,8M,16M; default 000.
// - Memory enters self refresh before stop or display-only idle while refresh enable bit 23 is set.
module dsbrc_top #(
	parameter CNT_W = 11
) (
	input wire clk,
	input wire reset,
	input wire [31:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire sdram_access,
	input wire low_power_req,
	input wire refresh_ack,
	input wire mode_set_done,
	output reg refresh_req,
	output reg self_refresh_active,
	output reg mem_clk_en,
	output reg mem_ras_n,
	output reg mem_cas_n,
	output reg mem_we_n,
	output reg mem_cke,
	output reg mode_set_req,
	output reg mode_set_bank,
	output reg [11:0] mode_set_addr,
	output reg [2:0] trcd_clocks,
	output reg [3:0] col_bits,
	output reg [2:0] trp_clocks,
	output reg trp_half,
	output reg [2:0] trc_clocks,
	output reg [2:0] tchr_clocks,
	output reg [5:0] upper_bank_size_mb
);

	// ========================================
	// State encoding of the refresh engine
	localparam ST_IDLE = 3'b001;
	localparam ST_AUTO = 3'b010;
	localparam ST_SELF = 3'b100;
	// One spare counter bit lets an interval run from the count field up to
	// 2^CNT_W inclusive, which is 2^11 - count + 1 clocks.
	localparam [CNT_W:0] CNT_WRAP = {1'b1, {CNT_W{1'b0}}};

	reg [16:0] bank_ctrl_lower;
	reg [16:0] upper_bank_control;
	reg [23:0] refresh_control;
	reg [4:0] bank_size_map;
	reg [11:0] sdram_mode_set_lower_bank;
	reg [11:0] sdram_mode_set_upper_bank;
	reg [CNT_W:0] interval_cnt;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [1:0] low_power_sync;
	reg [1:0] sdram_access_sync;

	wire refresh_enable_bit = refresh_control[`DSBRC_REF_EN];
	wire refresh_mode_bit = refresh_control[`DSBRC_REF_MODE];
	wire [1:0] memory_type = upper_bank_control[`DSBRC_MT_HI:`DSBRC_MT_LO];
	wire mem_clock_gating = bank_size_map[`DSBRC_CLKGATE];
	wire [2:0] upper_bank_size_map = bank_size_map[`DSBRC_MAP_HI:0];
	wire [CNT_W-1:0] refresh_count = refresh_control[`DSBRC_CNT_HI:0];
	wire is_sdram = (memory_type == `DSBRC_MT_SDRAM);
	wire low_power = low_power_sync[1];
	wire self_wanted = refresh_enable_bit & (refresh_mode_bit | low_power);
	wire cnt_wrap = (interval_cnt == CNT_WRAP);

	// Two-bit code plus base, saturating 11 for fields whose top code is unused
	function [2:0] code_clocks;
		input [1:0] code;
		input [2:0] base;
		input sat;
		begin
			if (sat && code == 2'h3)
				code_clocks = base + 3'h2;
			else
				code_clocks = base + {1'b0, code};
		end
	endfunction

	function [5:0] map_size;
		input [2:0] code;
		begin
			case (code)
				3'h4: map_size = 6'h02;
				3'h5: map_size = 6'h04;
				3'h6: map_size = 6'h08;
				3'h7: map_size = 6'h10;
				// Unused codes fall back to the full 32M map
				default: map_size = `DSBRC_RST_SIZE_MB;
			endcase
		end
	endfunction

	// ========================================
	// Input synchronisers
	// Both inputs are asynchronous; only the second stage feeds any logic
	always @(posedge clk) begin
		if (reset) begin
			low_power_sync <= 2'h0;
			sdram_access_sync <= 2'h0;
		end else begin
			low_power_sync <= {low_power_sync[0], low_power_req};
			sdram_access_sync <= {sdram_access_sync[0], sdram_access};
		end
	end

	// ========================================
	// Register port
	always @(posedge clk) begin
		if (reset) begin
			bank_ctrl_lower <= `DSBRC_RST_BANK;
			upper_bank_control <= `DSBRC_RST_BANK;
			refresh_control <= `DSBRC_RST_REFRESH;
			bank_size_map <= `DSBRC_RST_BANK_SIZE_MAP;
			sdram_mode_set_lower_bank <= `DSBRC_RST_MODE;
			sdram_mode_set_upper_bank <= `DSBRC_RST_MODE;
		end else if (reg_wr) begin
			case (reg_addr)
				`DSBRC_ADDR_BANK_LOWER: bank_ctrl_lower <= reg_wdata[16:0];
				`DSBRC_ADDR_BANK_UPPER: upper_bank_control <= reg_wdata[16:0];
				// Unused bits are never stored, so they read back zero
				`DSBRC_ADDR_REFRESH: refresh_control <= {reg_wdata[23:16], 5'h00,
					reg_wdata[10:0]};
				// Reserved bit 3 of the size map is never stored
				`DSBRC_ADDR_BANK_SIZE_MAP: bank_size_map <= {reg_wdata[4], 1'b0,
					reg_wdata[2:0]};
				`DSBRC_ADDR_MODE_LOWER: sdram_mode_set_lower_bank <= {2'h0, reg_wdata[9:0]};
				`DSBRC_ADDR_MODE_UPPER: sdram_mode_set_upper_bank <= {2'h0, reg_wdata[9:0]};
				default: ;
			endcase
		end
	end

	// Read data is zero outside its one response cycle
	always @(posedge clk) begin
		if (reset)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd) begin
			case (reg_addr)
				`DSBRC_ADDR_BANK_LOWER: reg_rdata <= {15'h0000, bank_ctrl_lower};
				`DSBRC_ADDR_BANK_UPPER: reg_rdata <= {15'h0000, upper_bank_control};
				`DSBRC_ADDR_REFRESH: reg_rdata <= {8'h00, refresh_control};
				`DSBRC_ADDR_BANK_SIZE_MAP: reg_rdata <= {27'h000_0000, bank_size_map};
				`DSBRC_ADDR_MODE_LOWER: reg_rdata <= {20'h0_0000, sdram_mode_set_lower_bank};
				`DSBRC_ADDR_MODE_UPPER: reg_rdata <= {20'h0_0000, sdram_mode_set_upper_bank};
				`DSBRC_ADDR_STATUS: reg_rdata <= {24'h00_0000, 2'h0, mode_set_req,
					self_refresh_active, refresh_req, state};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else
			reg_rdata <= 32'h0000_0000;
	end

	// ========================================
	// Refresh interval counter and engine
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				// A wrap that lands while a request still waits is dropped;
				// the arbiter must answer well inside one interval.
				if (self_wanted)
					next_state = ST_SELF;
				else if (refresh_enable_bit && cnt_wrap)
					next_state = ST_AUTO;
			end
			ST_AUTO: begin
				if (refresh_ack)
					next_state = ST_IDLE;
			end
			ST_SELF: begin
				if (!self_wanted)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk) begin
		if (reset) begin
			state <= ST_IDLE;
			interval_cnt <= {(CNT_W+1){1'b0}};
			refresh_req <= 1'b0;
			self_refresh_active <= 1'b0;
		end else begin
			state <= next_state;
			// Counts up from the count field and reloads on wrap. It keeps running
			// while a request waits, so the acknowledge latency does not stretch
			// the refresh period.
			if (!refresh_enable_bit || refresh_mode_bit)
				interval_cnt <= {1'b0, refresh_count};
			else if (cnt_wrap)
				interval_cnt <= {1'b0, refresh_count};
			else
				interval_cnt <= interval_cnt + {{CNT_W{1'b0}}, 1'b1};
			refresh_req <= (next_state == ST_AUTO);
			self_refresh_active <= (next_state == ST_SELF);
		end
	end

	// ========================================
	// Memory control levels; SDRAM self refresh holds CKE, RAS and CAS low with WE high
	always @(posedge clk) begin
		if (reset) begin
			mem_ras_n <= 1'b1;
			mem_cas_n <= 1'b1;
			mem_we_n <= 1'b1;
			mem_cke <= 1'b1;
			mem_clk_en <= 1'b1;
		end else begin
			// DRAM keeps RAS high with CAS held low; only SDRAM drops clock enable
			mem_ras_n <= (next_state != ST_SELF) | ~is_sdram;
			mem_cas_n <= (next_state != ST_SELF);
			mem_we_n <= 1'b1;
			mem_cke <= (next_state != ST_SELF) | ~is_sdram;
			mem_clk_en <= (next_state != ST_SELF) & (~mem_clock_gating |
				sdram_access_sync[1]);
		end
	end

	// ========================================
	// Mode-set issue, held until the bus side confirms
	// A newer write replaces a pending one and wins over a same-cycle done
	always @(posedge clk) begin
		if (reset) begin
			mode_set_req <= 1'b0;
			mode_set_bank <= 1'b0;
			mode_set_addr <= `DSBRC_RST_MODE;
		end else if (reg_wr && reg_addr == `DSBRC_ADDR_MODE_LOWER) begin
			mode_set_req <= 1'b1;
			mode_set_bank <= 1'b0;
			mode_set_addr <= {2'h0, reg_wdata[9:0]};
		end else if (reg_wr && reg_addr == `DSBRC_ADDR_MODE_UPPER) begin
			mode_set_req <= 1'b1;
			mode_set_bank <= 1'b1;
			mode_set_addr <= {2'h0, reg_wdata[9:0]};
		end else if (mode_set_done)
			mode_set_req <= 1'b0;
	end

	// ========================================
	// Decoded timing for the access sequencer
	always @(posedge clk) begin
		if (reset) begin
			// Matches the decode of the register reset values
			trcd_clocks <= `DSBRC_RST_TRCD;
			col_bits <= `DSBRC_COL_BASE;
			trp_clocks <= `DSBRC_RST_TRP;
			trp_half <= 1'b0;
			trc_clocks <= `DSBRC_RST_TRC;
			tchr_clocks <= `DSBRC_TCHR_BASE;
			upper_bank_size_mb <= `DSBRC_RST_SIZE_MB;
		end else begin
			if (is_sdram) begin
				trcd_clocks <= code_clocks(upper_bank_control[3:2], `DSBRC_TRCD_BASE,
					1'b1);
				col_bits <= `DSBRC_COL_BASE + ((upper_bank_control[1:0] == 2'h3) ? 4'h2 :
					{2'h0, upper_bank_control[1:0]});
				// Unsupported SDRAM code 11 saturates to the longest legal precharge
				trp_clocks <= code_clocks(refresh_control[`DSBRC_TRP_HI:`DSBRC_TRP_LO],
					`DSBRC_TRP_SD_BASE, 1'b1);
				trp_half <= 1'b0;
			end else begin
				trcd_clocks <= code_clocks(2'h2, `DSBRC_TRCD_BASE, 1'b1);
				col_bits <= `DSBRC_COL_BASE;
				// DRAM precharge is whole part plus a half clock
				trp_clocks <= code_clocks(refresh_control[`DSBRC_TRP_HI:`DSBRC_TRP_LO],
					`DSBRC_TRP_DR_BASE, 1'b0) - 3'h1;
				trp_half <= 1'b1;
			end
			trc_clocks <= code_clocks(refresh_control[`DSBRC_TRC_HI:`DSBRC_TRC_LO],
				`DSBRC_TRC_BASE, 1'b0);
			tchr_clocks <= code_clocks(refresh_control[`DSBRC_TCHR_HI:`DSBRC_TCHR_LO],
				`DSBRC_TCHR_BASE, 1'b0);
			upper_bank_size_mb <= map_size(upper_bank_size_map);
		end
	end

endmodule

//--- tb/dsbrc_assertions.sv
// Checker for the upper-bank refresh and configuration block.
// Sees only the top module ports; attached by bind.
`timescale 1ns/1ps
`include "dsbrc_defs.vh"
module dsbrc_chk (
	input wire clk,
	input wire reset,
	input wire [31:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire refresh_ack,
	input wire low_power_req,
	input wire refresh_req,
	input wire self_refresh_active,
	input wire mem_cas_n,
	input wire mem_we_n,
	input wire mem_cke,
	input wire mode_set_req,
	input wire mode_set_bank,
	input wire [11:0] mode_set_addr,
	input wire [2:0] trcd_clocks,
	input wire [5:0] upper_bank_size_mb
);
	// ========================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_unused_zero: assert property ($past(reg_rd) && $past(reg_addr) == `DSBRC_ADDR_REFRESH
		|-> reg_rdata[15:11] == 5'h0) else $error("unused bits set");
	a_req_hold: assert property (refresh_req && !refresh_ack && !low_power_req && !reg_wr
		|=> refresh_req) else $error("refresh request dropped");
	a_self_pins: assert property (self_refresh_active && $past(self_refresh_active)
		|-> !mem_cas_n && mem_we_n) else $error("self refresh levels");
	a_self_cke: assert property (!self_refresh_active && !$past(self_refresh_active)
		|-> mem_cke) else $error("clock enable low");
	a_self_entry: assert property (reg_wr && reg_addr == `DSBRC_ADDR_REFRESH
		&& reg_wdata[23:22] == 2'h3 |-> ##[1:8] self_refresh_active)
		else $error("no self refresh");
	a_mode_issue: assert property (reg_wr && reg_addr == `DSBRC_ADDR_MODE_UPPER
		|=> mode_set_req && mode_set_bank && mode_set_addr == {2'h0, $past(reg_wdata[9:0])})
		else $error("mode set not issued");
	a_trcd_range: assert property (trcd_clocks inside {3'h2, 3'h3, 3'h4})
		else $error("row to column delay");
	a_size_legal: assert property (upper_bank_size_mb inside {6'h02, 6'h04, 6'h08, 6'h10,
		6'h20}) else $error("bank size");
endmodule
bind dsbrc_top dsbrc_chk u_dsbrc_chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .refresh_ack, .low_power_req, .refresh_req, .self_refresh_active, .mem_cas_n,
	.mem_we_n, .mem_cke, .mode_set_req, .mode_set_bank, .mode_set_addr, .trcd_clocks,
	.upper_bank_size_mb);

//--- tb/dsbrc_mem_model.sv
// Model of the arbiter and SDRAM traffic beside the block.
// Assumes the bench clock; answers after a fixed delay.
`timescale 1ns/1ps
module dsbrc_mem_model #(
	parameter ACK_DLY = 3
) (
	input wire clk,
	input wire reset,
	input wire refresh_req,
	input wire mode_set_req,
	input wire busy_en,
	output logic refresh_ack = 1'b0,
	output logic mode_set_done = 1'b0,
	output logic sdram_access = 1'b0
);
	int n = 0;
	// ========================================
	// Access traffic, updated every 80 ns, 3 ns before a clk rising edge
	initial begin
		#7;
		forever #80 sdram_access = busy_en & ~sdram_access;
	end
	always @(posedge clk) begin
		n <= (reset || !refresh_req) ? 0 : n + 1;
		refresh_ack <= refresh_req && n == ACK_DLY;
		mode_set_done <= mode_set_req && !mode_set_done;
	end
endmodule

//--- tb/dsbrc_top_tb.sv
// Self-checking bench for the upper-bank refresh and configuration block.
// Assumes the memory model and the design defines header.
`timescale 1ns/1ps
`include "dsbrc_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
`define WAITV(s, v) begin for (i = 0; i < 200 && (s) !== (v); i++) tick(1); \
	if (i == 200) begin $display("[ERR] wait exp %h got %h", v, s); mismatches++; \
	end_of_test(); end end
module dsbrc_top_tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [31:0] reg_addr = 32'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic low_power_req = 1'b0;
	logic busy_en = 1'b0;
	logic [2:0] map_code [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
	logic [5:0] map_mb [5] = '{6'h20, 6'h02, 6'h04, 6'h08, 6'h10};
	logic [2:0] cl_code [3] = '{3'h0, 3'h2, 3'h3};
	wire [31:0] reg_rdata;
	wire [11:0] mode_set_addr;
	wire [2:0] trcd_clocks, trp_clocks, trc_clocks, tchr_clocks;
	wire [3:0] col_bits;
	wire [5:0] upper_bank_size_mb;
	wire refresh_ack, mode_set_done, sdram_access, refresh_req, self_refresh_active;
	wire mem_clk_en, mem_ras_n, mem_cas_n, mem_we_n, mem_cke, mode_set_req;
	wire mode_set_bank, trp_half;
	int mismatches = 0;
	int check_count = 0;
	int i;
	int hi_len;
	always #10 clk = ~clk;
	dsbrc_top u_dsbrc_top (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.sdram_access, .low_power_req, .refresh_ack, .mode_set_done, .refresh_req,
		.self_refresh_active, .mem_clk_en, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_cke,
		.mode_set_req, .mode_set_bank, .mode_set_addr, .trcd_clocks, .col_bits, .trp_clocks,
		.trp_half, .trc_clocks, .tchr_clocks, .upper_bank_size_mb);
	dsbrc_mem_model u_dsbrc_mem_model (.clk, .reset, .refresh_req, .mode_set_req, .busy_en,
		.refresh_ack, .mode_set_done, .sdram_access);
	// ========================================
	// Register port tasks
	task tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task wr(input [31:0] a, input [31:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [31:0] a, input [31:0] e);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK("rdata", e, reg_rdata)
	endtask
	task end_of_test;
		if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ========================================
	// Scenarios
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rd(`DSBRC_ADDR_REFRESH, 32'h00ac_0000);
		rd(`DSBRC_ADDR_BANK_UPPER, 32'h0001_8008);
		rd(`DSBRC_ADDR_BANK_SIZE_MAP, 32'h0);
		rd(`DSBRC_ADDR_STATUS, 32'h1);
		// Every upper bank type used below pairs legally with static memory below it
		wr(`DSBRC_ADDR_BANK_LOWER, 32'h0);
		rd(`DSBRC_ADDR_BANK_LOWER, 32'h0);
		`CHK("trp", 3'h4, trp_clocks)
		`CHK("trc", 3'h7, trc_clocks)
		`CHK("tchr", 3'h1, tchr_clocks)
		for (i = 0; i < 3; i++) begin
			wr(`DSBRC_ADDR_REFRESH, {10'h0, i[1:0], i[1:0], i[1:0], 16'h0});
			wr(`DSBRC_ADDR_BANK_UPPER, {28'h0001_800, i[1:0], i[1:0]});
			tick(2);
			`CHK("trcd", i[2:0] + 3'h2, trcd_clocks)
			`CHK("col", i[3:0] + 4'h8, col_bits)
			`CHK("trp", i[2:0] + 3'h2, trp_clocks)
			`CHK("trc", i[2:0] + 3'h4, trc_clocks)
			`CHK("tchr", i[2:0] + 3'h1, tchr_clocks)
		end
		wr(`DSBRC_ADDR_REFRESH, 32'h003f_ffff);
		rd(`DSBRC_ADDR_REFRESH, 32'h003f_07ff);
		`CHK("trc", 3'h7, trc_clocks)
		`CHK("tchr", 3'h4, tchr_clocks)
		for (i = 1; i < 4; i++) begin
			wr(`DSBRC_ADDR_BANK_UPPER, {15'h0, i[1:0], 15'h0});
			tick(2);
			`CHK("half", i != 3, trp_half)
			`CHK("trp", 3'h4, trp_clocks)
		end
		for (int k = 0; k < 5; k++) begin
			wr(`DSBRC_ADDR_BANK_SIZE_MAP, {29'h1, map_code[k]});
			rd(`DSBRC_ADDR_BANK_SIZE_MAP, {29'h0, map_code[k]});
			`CHK("size", map_mb[k], upper_bank_size_mb)
		end
		wr(`DSBRC_ADDR_BANK_SIZE_MAP, 32'h10);
		tick(8);
		`CHK("clk_en", 1'b0, mem_clk_en)
		busy_en <= 1'b1;
		`WAITV(mem_clk_en, 1'b1)
		busy_en <= 1'b0;
		`WAITV(mem_clk_en, 1'b0)
		wr(`DSBRC_ADDR_BANK_SIZE_MAP, 32'h0);
		tick(8);
		`CHK("clk_en", 1'b1, mem_clk_en)
		// Only legal mode values: burst write 0, test field 00, latency 0/2/3
		wr(`DSBRC_ADDR_MODE_UPPER, 32'h0000_0c20);
		#1 `CHK("ms_bank", 1'b1, mode_set_bank)
		`CHK("ms_req", 1'b1, mode_set_req)
		`WAITV(mode_set_req, 1'b0)
		rd(`DSBRC_ADDR_MODE_UPPER, 32'h20);
		for (int k = 0; k < 3; k++) begin
			wr(`DSBRC_ADDR_MODE_LOWER, {25'h0, cl_code[k], 4'h0});
			#1 `CHK("ms_addr", {5'h0, cl_code[k], 4'h0}, mode_set_addr)
			`CHK("ms_bank", 1'b0, mode_set_bank)
			`WAITV(mode_set_req, 1'b0)
		end
		wr(`DSBRC_ADDR_REFRESH, 32'h0080_07f0);
		`WAITV(refresh_req, 1'b1)
		`WAITV(refresh_req, 1'b0)
		hi_len = i;
		`WAITV(refresh_req, 1'b1)
		// Rise to rise spans one full interval for any acknowledge latency shorter than one interval
		`CHK("interval", `DSBRC_CNT_TOP + 12'h001 - 12'h7f0, hi_len + i)
		`WAITV(refresh_req, 1'b0)
		wr(`DSBRC_ADDR_REFRESH, 32'h0000_07f0);
		tick(60);
		`CHK("req_off", 1'b0, refresh_req)
		wr(`DSBRC_ADDR_REFRESH, 32'h00c0_07f0);
		`WAITV(self_refresh_active, 1'b1)
		tick(1);
		`CHK("ras_n", 1'b0, mem_ras_n)
		`CHK("cke", 1'b0, mem_cke)
		`CHK("cas_n", 1'b0, mem_cas_n)
		`CHK("we_n", 1'b1, mem_we_n)
		rd(`DSBRC_ADDR_STATUS, 32'h14);
		wr(`DSBRC_ADDR_REFRESH, 32'h0080_07f0);
		`WAITV(self_refresh_active, 1'b0)
		low_power_req <= 1'b1;
		`WAITV(self_refresh_active, 1'b1)
		low_power_req <= 1'b0;
		`WAITV(self_refresh_active, 1'b0)
		wr(32'h01c8_0040, 32'hffff_ffff);
		rd(32'h01c8_0040, 32'h0);
		rd(`DSBRC_ADDR_REFRESH, 32'h0080_07f0);
		end_of_test();
	end
endmodule
